// ---- testbench/flash_array_model.sv ----
// Behavioural program flash array driven by the sequencer's command strobes.
// Assumes one command per clock; programming can only clear bits, as in real flash.
`timescale 1ns/1ps
`default_nettype none
module flash_array_model (
   // Clock
   input wire logic                                     hclk,
   // Command from the sequencer
   input wire flash_row_write_sequencer_pkg::flash_cmd_s flash_cmd
);
   logic [13:0] mem [int];
   int          n_words = 0;
   int          n_erase = 0;

   function automatic logic [13:0] peek(input int a);
      if (mem.exists(a))
         return mem[a];
      return 14'h3FFF;
   endfunction : peek

   always @(posedge hclk) begin
      int a;
      a = int'(flash_cmd.addr);
      if (flash_cmd.row_erase) begin
         n_erase++;
         for (int i = 0; i < 16; i++)
            mem[(a & 32'h7FF0) + i] = 14'h3FFF;
      end
      // No erase here: unerased bits stay cleared
      if (flash_cmd.word_we) begin
         n_words++;
         mem[a] = peek(a) & flash_cmd.wdata;
      end
   end
endmodule : flash_array_model
`default_nettype wire

// ---- testbench/flash_row_write_sequencer_checker.sv ----
// Concurrent checks on the sequencer's flash command and stall outputs.
// Assumes it is bound into flash_row_write_sequencer with the same PROG_CYCLES.
`timescale 1ns/1ps
`default_nettype none
module flash_row_write_sequencer_checker #(
   parameter int unsigned PROG_CYCLES = 20
) (
   // Clock and reset
   input wire logic                                     hclk,
   input wire logic                                     hresetn,
   // Watched outputs
   input wire logic                                     cpu_stall,
   input wire flash_row_write_sequencer_pkg::flash_cmd_s flash_cmd
);
   // ----------------------------------------------------------------
   // Stall length counter
   // ----------------------------------------------------------------
   logic [31:0] stall_cnt_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         stall_cnt_q <= 32'h0;
      else
         stall_cnt_q <= cpu_stall ? stall_cnt_q + 32'h1 : 32'h0;
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // Sixteen words split in two runs to keep the unrolled repetition short
   sequence s_burst;
      flash_cmd.word_we [*8] ##1 flash_cmd.word_we [*8];
   endsequence

   a_burst_sixteen: assert property ($rose(flash_cmd.word_we) |-> s_burst ##1 !flash_cmd.word_we)
      else $error("commit burst is not sixteen words");
   a_burst_aligned: assert property ($rose(flash_cmd.word_we) |-> flash_cmd.addr[3:0] == 4'h0)
      else $error("commit burst not row aligned");
   a_burst_step: assert property (flash_cmd.word_we && $past(flash_cmd.word_we)
      |-> flash_cmd.addr == $past(flash_cmd.addr) + 15'h1)
      else $error("commit burst address not stepping");
   a_word_stalled: assert property (flash_cmd.word_we |-> cpu_stall)
      else $error("word programmed without stall");
   a_erase_stalled: assert property (flash_cmd.row_erase |-> cpu_stall)
      else $error("row erased without stall");
   a_erase_whole_row: assert property (flash_cmd.row_erase |-> flash_cmd.addr[3:0] == 4'h0 && !flash_cmd.word_we)
      else $error("erase not on whole row");
   a_setup_first: assert property ($rose(cpu_stall) |=> flash_cmd.word_we || flash_cmd.row_erase)
      else $error("flash cycle not right after setup");
   a_stall_length: assert property ($fell(cpu_stall)
      |-> stall_cnt_q >= PROG_CYCLES && stall_cnt_q <= PROG_CYCLES + 40)
      else $error("stall length out of range");
endmodule : flash_row_write_sequencer_checker

bind flash_row_write_sequencer flash_row_write_sequencer_checker #(.PROG_CYCLES(PROG_CYCLES)) u_checker (
   .hclk      (hclk),
   .hresetn   (hresetn),
   .cpu_stall (cpu_stall),
   .flash_cmd (flash_cmd)
);
`default_nettype wire

// ---- testbench/test_flash_row_write_sequencer.sv ----
// Self-checking bench: AHB-Lite register sequences against a flash array model.
// Assumes zero wait states and PROG_CYCLES of 20.
`timescale 1ns/1ps
`default_nettype none
`include "flash_row_write_sequencer_map.svh"
module test_flash_row_write_sequencer;
   logic                                      hclk;
   logic                                      hresetn;
   logic                                      hsel;
   logic [31:0]                               haddr;
   logic [1:0]                                htrans;
   logic                                      hwrite;
   logic [31:0]                               hwdata;
   logic [31:0]                               hrdata;
   logic                                      hreadyout;
   logic                                      hresp;
   logic [1:0]                                wp_range;
   logic                                      cpu_stall;
   flash_row_write_sequencer_pkg::flash_cmd_s flash_cmd;
   int                                        miscompares;
   int                                        n_compared;
   int                                        cycles;
   int                                        w0;
   logic [31:0]                               rd;
   logic [31:0]                               hrdata_q;
   logic [13:0]                               dat [4];

   flash_row_write_sequencer #(.PROG_CYCLES(20)) dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .write_protect_range(wp_range), .cpu_stall(cpu_stall), .flash_cmd(flash_cmd)
   );
   flash_array_model u_flash (.hclk(hclk), .flash_cmd(flash_cmd));

   initial hclk = 1'h0;
   always #5 hclk = ~hclk;
   // Read data as it stood at the data phase's closing edge
   always @(posedge hclk) hrdata_q <= hrdata;

   // ----------------------------------------------------------------
   // Bus, compare and report tasks
   // ----------------------------------------------------------------
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'h1;
      haddr  <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      #1 rd = hrdata_q;
   endtask : bus

   task automatic cmp32(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t %s: got %h expected %h", $time, m, got, exp);
      end
   endtask : cmp32

   task automatic go(input logic [7:0] ctl);
      bus(1'h1, `FRWS_OFS_UNLOCK, 32'h55);
      bus(1'h1, `FRWS_OFS_UNLOCK, 32'hAA);
      bus(1'h1, `FRWS_OFS_CONTROL, {24'h0, ctl | 8'h02});
   endtask : go

   task automatic load(input logic [7:0] lo, input logic [13:0] d, input logic [7:0] ctl);
      bus(1'h1, `FRWS_OFS_ADDR_LOW, {24'h0, lo});
      bus(1'h1, `FRWS_OFS_DATA_LOW, {24'h0, d[7:0]});
      bus(1'h1, `FRWS_OFS_DATA_HIGH, {26'h0, d[13:8]});
      go(ctl);
   endtask : load

   task automatic wait_done(input logic [31:0] exp);
      for (int i = 0; i < 200; i++) begin
         bus(1'h0, `FRWS_OFS_CONTROL, 32'h0);
         if (rd[1] === 1'h0)
            break;
      end
      cmp32(rd, exp, "ctl when done");
      cmp32({31'h0, cpu_stall}, 32'h0, "stall when done");
   endtask : wait_done

   task automatic wrap_up;
      $display("compared %0d, mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : wrap_up

   // Hang guard, tests need ~400 cycles
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         $display("[FAIL] %0t timeout", $time);
         wrap_up();
      end
   end

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      {hresetn, hsel, haddr, htrans, hwrite, hwdata} = '0;
      wp_range = 2'h3;
      {miscompares, n_compared, cycles} = '0;
      dat = '{14'h1234, 14'h0AB1, 14'h2C3D, 14'h3005};
      repeat (2) @(posedge hclk);
      hresetn <= 1'h1;
      bus(1'h0, `FRWS_OFS_CONTROL, 32'h0);
      cmp32(rd, 32'h0, "ctl reset");
      bus(1'h0, `FRWS_OFS_STATUS, 32'h0);
      cmp32(rd, 32'h1, "status reset");
      bus(1'h0, 8'h1C, 32'h0);
      cmp32(rd, 32'h0, "unmapped read");
      $display("test reset done");
      bus(1'h1, `FRWS_OFS_ADDR_HIGH, 32'h0A);
      bus(1'h1, `FRWS_OFS_CONTROL, 32'hA4);
      for (int i = 0; i < 3; i++) begin
         load(8'h30 + 8'(i), dat[i], 8'hA4);
         repeat (4) @(posedge hclk);
         cmp32({31'h0, cpu_stall}, 32'h0, "stall on latch load");
         bus(1'h0, `FRWS_OFS_CONTROL, 32'h0);
         cmp32(rd, 32'hA4, "ctl after load");
      end
      cmp32(u_flash.n_words, 32'h0, "load wrote flash");
      $display("test latch load done");
      bus(1'h1, `FRWS_OFS_CONTROL, 32'h84);
      bus(1'h1, `FRWS_OFS_UNLOCK, 32'h55);
      bus(1'h1, `FRWS_OFS_ADDR_LOW, 32'h33);
      bus(1'h1, `FRWS_OFS_UNLOCK, 32'hAA);
      bus(1'h1, `FRWS_OFS_CONTROL, 32'h86);
      bus(1'h1, `FRWS_OFS_UNLOCK, 32'hAA);
      bus(1'h1, `FRWS_OFS_UNLOCK, 32'h55);
      bus(1'h1, `FRWS_OFS_CONTROL, 32'h86);
      repeat (6) @(posedge hclk);
      bus(1'h0, `FRWS_OFS_CONTROL, 32'h0);
      cmp32(rd, 32'h84, "ctl broken unlock");
      cmp32(u_flash.n_words, 32'h0, "broken unlock wrote");
      $display("test broken unlock done");
      load(8'h33, dat[3], 8'h84);
      wait_done(32'h84);
      cmp32(u_flash.n_words, 32'd16, "words per commit");
      cmp32(u_flash.n_erase, 32'h0, "erase during commit");
      for (int i = 0; i < 16; i++)
         cmp32(u_flash.peek(32'h0A30 + i), i < 4 ? dat[i] : 14'h3FFF, "row word");
      load(8'h45, 14'h1555, 8'h84);
      wait_done(32'h84);
      for (int i = 0; i < 16; i++)
         cmp32(u_flash.peek(32'h0A40 + i), i == 5 ? 14'h1555 : 14'h3FFF, "latch reset");
      load(8'h30, 14'h0FF0, 8'h84);
      wait_done(32'h84);
      cmp32(u_flash.peek(32'h0A30), 14'h0230, "no auto erase");
      $display("test commit done");
      bus(1'h1, `FRWS_OFS_ADDR_LOW, 32'h37);
      bus(1'h1, `FRWS_OFS_CONTROL, 32'h94);
      w0 = u_flash.n_words;
      go(8'h94);
      wait_done(32'h94);
      cmp32(u_flash.n_erase, 32'h1, "erase count");
      cmp32(u_flash.n_words - w0, 32'h0, "erase wrote");
      for (int i = 0; i < 16; i++)
         cmp32(u_flash.peek(32'h0A30 + i), 14'h3FFF, "erased word");
      cmp32(u_flash.peek(32'h0A45), 14'h1555, "neighbour kept");
      $display("test erase done");
      bus(1'h1, `FRWS_OFS_CONTROL, 32'h80);
      go(8'h84);
      repeat (6) @(posedge hclk);
      bus(1'h0, `FRWS_OFS_CONTROL, 32'h0);
      cmp32(rd, 32'h84, "late permit");
      cmp32(u_flash.n_words - w0, 32'h0, "no permit wrote");
      wp_range <= 2'h2;
      bus(1'h1, `FRWS_OFS_ADDR_HIGH, 32'h01);
      bus(1'h1, `FRWS_OFS_ADDR_LOW, 32'h00);
      go(8'h84);
      repeat (6) @(posedge hclk);
      bus(1'h0, `FRWS_OFS_CONTROL, 32'h0);
      cmp32(rd, 32'h8C, "refused");
      cmp32(u_flash.n_words - w0, 32'h0, "protected wrote");
      bus(1'h1, `FRWS_OFS_CONTROL, 32'h84);
      wp_range <= 2'h3;
      $display("test refusals done");
      wrap_up();
   end
endmodule : test_flash_row_write_sequencer
`default_nettype wire

// ---- verilog/flash_row_write_sequencer.sv ----
// Flash self-programming sequencer: unlock, 16 write latches, row program and row erase.
// Assumes a single AHB-Lite master on hclk and a flash array that accepts one word or erase per strobe.
//
// Our own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "flash_row_write_sequencer_map.svh"

// Summary of operation
// - Program never erases the target first
// - At most 16 words, row aligned
// - Latches reset to 3FFF after write
// - Latch load and program need unlock
// - Latch-only set: store word, no write
// - Latch-only clear: load last, program block
// - Commit programs all latches, loaded or not
// - Two setup cycles after initiate
// - Processor stalls only during commit program or row erase
// - Latch loads never stall the processor
// - Resume after stall ends
// - Erase works on whole rows only
// - Erase-select erases row, stalls until done
// - Initiate needs permit already set
// - Hardware clears initiate on completion
// - Refuse protected target addresses
// - Row and latch block 16 words aligned
module flash_row_write_sequencer #(
   parameter int unsigned PROG_CYCLES = `FRWS_PROG_CYCLES
) (
   // Clock and reset
   input  wire logic                                hclk,
   input  wire logic                                hresetn,
   // AHB-Lite slave
   input  wire logic                                hsel,
   input  wire logic [31:0]                         haddr,
   input  wire logic [1:0]                          htrans,
   input  wire logic                                hwrite,
   input  wire logic [2:0]                          hsize,
   input  wire logic [31:0]                         hwdata,
   input  wire logic                                hready,
   output logic [31:0]                              hrdata,
   output logic                                     hreadyout,
   output logic                                     hresp,
   // Configuration
   input  wire logic [1:0]                          write_protect_range,
   // Processor and flash array
   output logic                                     cpu_stall,
   output flash_row_write_sequencer_pkg::flash_cmd_s flash_cmd
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic is_protected(input logic [1:0] range, input logic [14:0] addr);
      case (range)
         2'b11:   is_protected = 1'b0;
         2'b10:   is_protected = addr < `FRWS_WP_LIMIT_HALF;
         2'b01:   is_protected = addr < `FRWS_WP_LIMIT_MOST;
         default: is_protected = addr <= `FRWS_WP_LIMIT_ALL;
      endcase
   endfunction : is_protected

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   flash_row_write_sequencer_pkg::seq_state_e state_q;
   logic [13:0] latch_q [`FRWS_LATCH_COUNT];
   logic [7:0]  addr_low_q;
   logic [6:0]  addr_high_q;
   logic [7:0]  data_low_q;
   logic [5:0]  data_high_q;
   logic        wr_q;
   logic        permit_q;
   logic        error_q;
   logic        erase_sel_q;
   logic        latch_only_q;
   logic        cfg_sel_q;
   logic        prog_sel_q;
   logic [1:0]  key_stage_q;
   logic [3:0]  word_idx_q;
   logic [17:0] wait_cnt_q;
   logic [1:0]  setup_cnt_q;
   logic        op_erase_q;

   // ----------------------------------------------------------------
   // AHB-Lite address and data phase
   // ----------------------------------------------------------------
   logic       dph_write_q;
   logic       dph_read_q;
   logic [7:0] dph_addr_q;
   logic       addr_take;

   assign addr_take = hsel && htrans[1] && hready;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dph_write_q <= 1'b0;
         dph_read_q  <= 1'b0;
         dph_addr_q  <= 8'h00;
      end else if (hready) begin
         dph_write_q <= addr_take && hwrite;
         dph_read_q  <= addr_take && !hwrite;
         dph_addr_q  <= {haddr[7:2], 2'b00};
      end
   end

   // Registers never insert wait states; the core stall is a separate signal.
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   logic wr_ctl;
   logic wr_key;
   assign wr_ctl = dph_write_q && (dph_addr_q == `FRWS_OFS_CONTROL);
   assign wr_key = dph_write_q && (dph_addr_q == `FRWS_OFS_UNLOCK);

   // ----------------------------------------------------------------
   // Unlock sequence
   // ----------------------------------------------------------------
   // Any other register write between the keys and the initiate breaks the sequence.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         key_stage_q <= 2'd0;
      end else if (wr_key) begin
         if (hwdata[7:0] == `FRWS_KEY_FIRST) begin
            key_stage_q <= 2'd1;
         end else if (hwdata[7:0] == `FRWS_KEY_SECOND && key_stage_q == 2'd1) begin
            key_stage_q <= 2'd2;
         end else begin
            key_stage_q <= 2'd0;
         end
      end else if (dph_write_q) begin
         key_stage_q <= 2'd0;
      end
   end

   // ----------------------------------------------------------------
   // Initiate decision
   // ----------------------------------------------------------------
   logic [14:0] target_addr;
   logic        initiate;
   logic        op_ok;
   logic        go_latch;
   logic        go_commit;
   logic        go_erase;
   logic        refused;
   logic        op_done;

   assign target_addr = {addr_high_q, addr_low_q};
   assign initiate    = wr_ctl && hwdata[`FRWS_CTL_WR] && (key_stage_q == 2'd2)
                        && permit_q
                        && (state_q == flash_row_write_sequencer_pkg::ST_IDLE);
   assign op_ok       = prog_sel_q && !cfg_sel_q && !is_protected(write_protect_range, target_addr);
   assign go_erase    = initiate && op_ok && erase_sel_q;
   assign go_latch    = initiate && op_ok && !erase_sel_q && latch_only_q;
   assign go_commit   = initiate && op_ok && !erase_sel_q && !latch_only_q;
   assign refused     = initiate && !op_ok;
   assign op_done     = (state_q == flash_row_write_sequencer_pkg::ST_WAIT) && (wait_cnt_q == 18'd0);

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         permit_q     <= 1'b0;
         erase_sel_q  <= 1'b0;
         latch_only_q <= 1'b0;
         cfg_sel_q    <= 1'b0;
         prog_sel_q   <= 1'b0;
      end else if (wr_ctl) begin
         // Permit may drop mid-operation; the running operation carries on.
         permit_q     <= hwdata[`FRWS_CTL_PERMIT];
         erase_sel_q  <= hwdata[`FRWS_CTL_ERASE];
         latch_only_q <= hwdata[`FRWS_CTL_LATCH_ONLY];
         cfg_sel_q    <= hwdata[`FRWS_CTL_CFG_SEL];
         prog_sel_q   <= hwdata[`FRWS_CTL_PROG_SEL];
      end
   end

   // Initiate bit reads 1 from a started commit or erase until it completes.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
      end else if (go_commit || go_erase) begin
         wr_q <= 1'b1;
      end else if (op_done) begin
         wr_q <= 1'b0;
      end
   end

   // Refusal flag: a refusal in the same cycle as a clearing write wins.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         error_q <= 1'b0;
      end else if (refused) begin
         error_q <= 1'b1;
      end else if (wr_ctl && !hwdata[`FRWS_CTL_ERROR]) begin
         error_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Address and data registers
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_low_q  <= 8'h00;
         addr_high_q <= 7'h00;
         data_low_q  <= 8'h00;
         data_high_q <= 6'h00;
      end else if (dph_write_q) begin
         case (dph_addr_q)
            `FRWS_OFS_ADDR_LOW:  addr_low_q  <= hwdata[7:0];
            `FRWS_OFS_ADDR_HIGH: addr_high_q <= hwdata[6:0];
            `FRWS_OFS_DATA_LOW:  data_low_q  <= hwdata[7:0];
            `FRWS_OFS_DATA_HIGH: data_high_q <= hwdata[5:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Write latches
   // ----------------------------------------------------------------
   // The low four address bits pick the latch, so a block never crosses a row.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < `FRWS_LATCH_COUNT; i++) begin
            latch_q[i] <= `FRWS_ERASED_WORD;
         end
      end else if (op_done && !op_erase_q) begin
         for (int i = 0; i < `FRWS_LATCH_COUNT; i++) begin
            latch_q[i] <= `FRWS_ERASED_WORD;
         end
      end else if (go_latch || go_commit) begin
         latch_q[addr_low_q[3:0]] <= {data_high_q, data_low_q};
      end
   end

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q     <= flash_row_write_sequencer_pkg::ST_IDLE;
         setup_cnt_q <= 2'd0;
         word_idx_q  <= 4'd0;
         wait_cnt_q  <= 18'd0;
         op_erase_q  <= 1'b0;
      end else begin
         case (state_q)
            flash_row_write_sequencer_pkg::ST_IDLE: begin
               // Latch loads finish here without leaving idle.
               if (go_commit || go_erase) begin
                  state_q     <= flash_row_write_sequencer_pkg::ST_SETUP;
                  setup_cnt_q <= 2'(`FRWS_SETUP_CYCLES - 1);
                  op_erase_q  <= go_erase;
               end
            end
            flash_row_write_sequencer_pkg::ST_SETUP: begin
               if (setup_cnt_q == 2'd0) begin
                  word_idx_q <= 4'd0;
                  state_q    <= op_erase_q ? flash_row_write_sequencer_pkg::ST_ERASE
                                           : flash_row_write_sequencer_pkg::ST_PROG;
               end else begin
                  setup_cnt_q <= setup_cnt_q - 2'd1;
               end
            end
            flash_row_write_sequencer_pkg::ST_PROG: begin
               // Every latch goes out, loaded or still erased.
               word_idx_q <= word_idx_q + 4'd1;
               if (word_idx_q == 4'(`FRWS_LATCH_COUNT - 1)) begin
                  state_q    <= flash_row_write_sequencer_pkg::ST_WAIT;
                  wait_cnt_q <= 18'(PROG_CYCLES - 1);
               end
            end
            flash_row_write_sequencer_pkg::ST_ERASE: begin
               state_q    <= flash_row_write_sequencer_pkg::ST_WAIT;
               wait_cnt_q <= 18'(PROG_CYCLES - 1);
            end
            flash_row_write_sequencer_pkg::ST_WAIT: begin
               if (wait_cnt_q == 18'd0) begin
                  state_q <= flash_row_write_sequencer_pkg::ST_IDLE;
               end else begin
                  wait_cnt_q <= wait_cnt_q - 18'd1;
               end
            end
            default: begin
               state_q <= flash_row_write_sequencer_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Outputs to processor and flash array
   // ----------------------------------------------------------------
   // Stall covers the flash cycle and the second of the two setup cycles, not the first.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cpu_stall <= 1'b0;
      end else begin
         cpu_stall <= ((state_q == flash_row_write_sequencer_pkg::ST_SETUP) && (setup_cnt_q == 2'd0))
                      || (state_q == flash_row_write_sequencer_pkg::ST_PROG)
                      || (state_q == flash_row_write_sequencer_pkg::ST_ERASE)
                      || ((state_q == flash_row_write_sequencer_pkg::ST_WAIT) && (wait_cnt_q != 18'd0));
      end
   end

   // Programming only writes words; no erase strobe accompanies it.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flash_cmd <= '0;
      end else begin
         flash_cmd.word_we   <= (state_q == flash_row_write_sequencer_pkg::ST_PROG);
         flash_cmd.row_erase <= (state_q == flash_row_write_sequencer_pkg::ST_ERASE);
         flash_cmd.addr      <= {addr_high_q, addr_low_q[7:4], word_idx_q};
         flash_cmd.wdata     <= latch_q[word_idx_q];
      end
   end

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   always_comb begin
      hrdata = 32'h0000_0000;
      if (dph_read_q) begin
         case (dph_addr_q)
            `FRWS_OFS_CONTROL: begin
               hrdata[`FRWS_CTL_WR]         = wr_q;
               hrdata[`FRWS_CTL_PERMIT]     = permit_q;
               hrdata[`FRWS_CTL_ERROR]      = error_q;
               hrdata[`FRWS_CTL_ERASE]      = erase_sel_q;
               hrdata[`FRWS_CTL_LATCH_ONLY] = latch_only_q;
               hrdata[`FRWS_CTL_CFG_SEL]    = cfg_sel_q;
               hrdata[`FRWS_CTL_PROG_SEL]   = prog_sel_q;
            end
            `FRWS_OFS_ADDR_LOW:  hrdata[7:0] = addr_low_q;
            `FRWS_OFS_ADDR_HIGH: hrdata[6:0] = addr_high_q;
            `FRWS_OFS_DATA_LOW:  hrdata[7:0] = data_low_q;
            `FRWS_OFS_DATA_HIGH: hrdata[5:0] = data_high_q;
            `FRWS_OFS_STATUS:    hrdata[6:0] = {key_stage_q, state_q};
            default:             hrdata = 32'h0000_0000;
         endcase
      end
   end

endmodule : flash_row_write_sequencer

`default_nettype wire

// ---- verilog/flash_row_write_sequencer_map.svh ----
// Register offsets, field positions, reset values and timing counts of the flash row write sequencer.
// Assumes a 32-bit AHB-Lite register bus clocked at 100 MHz.
`ifndef FLASH_ROW_WRITE_SEQUENCER_MAP_SVH
`define FLASH_ROW_WRITE_SEQUENCER_MAP_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define FRWS_OFS_CONTROL    8'h00
`define FRWS_OFS_UNLOCK     8'h04
`define FRWS_OFS_ADDR_LOW   8'h08
`define FRWS_OFS_ADDR_HIGH  8'h0C
`define FRWS_OFS_DATA_LOW   8'h10
`define FRWS_OFS_DATA_HIGH  8'h14
`define FRWS_OFS_STATUS     8'h18

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define FRWS_CTL_WR         1
`define FRWS_CTL_PERMIT     2
`define FRWS_CTL_ERROR      3
`define FRWS_CTL_ERASE      4
`define FRWS_CTL_LATCH_ONLY 5
`define FRWS_CTL_CFG_SEL    6
`define FRWS_CTL_PROG_SEL   7

// ----------------------------------------------------------------
// Unlock keys and reset values
// ----------------------------------------------------------------
`define FRWS_KEY_FIRST      8'h55
`define FRWS_KEY_SECOND     8'hAA
`define FRWS_ERASED_WORD    14'h3FFF
`define FRWS_LATCH_COUNT    16

// ----------------------------------------------------------------
// Write-protect segment limits (word addresses below the limit are protected, up to and including it for ALL)
// ----------------------------------------------------------------
`define FRWS_WP_LIMIT_HALF  15'h0200
`define FRWS_WP_LIMIT_MOST  15'h0400
`define FRWS_WP_LIMIT_ALL   15'h7FFF

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FRWS_CLK_PERIOD_NS  10
`define FRWS_SETUP_CYCLES   2
`define FRWS_PROG_TIME_NS   2000000
`define FRWS_PROG_CYCLES    (`FRWS_PROG_TIME_NS / `FRWS_CLK_PERIOD_NS)

`endif

// ---- verilog/flash_row_write_sequencer_pkg.sv ----
// Types shared by the flash row write sequencer and its bench.
// Assumes nothing beyond the map header for numbers.
`default_nettype none

package flash_row_write_sequencer_pkg;

   // ----------------------------------------------------------------
   // Sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      ST_IDLE  = 5'b00001,
      ST_SETUP = 5'b00010,
      ST_PROG  = 5'b00100,
      ST_ERASE = 5'b01000,
      ST_WAIT  = 5'b10000
   } seq_state_e;

   // ----------------------------------------------------------------
   // Command to the flash array
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        word_we;
      logic        row_erase;
      logic [14:0] addr;
      logic [13:0] wdata;
   } flash_cmd_s;

endpackage : flash_row_write_sequencer_pkg

`default_nettype wire
